// [serial_port_uart_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module serial_port_uart_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic timer1_ovf = 1'b0;
    logic timer2_ovf = 1'b0;
    logic t_run = 1'b0;
    logic rxd_out, rxd_oe, txd, peer_rxd;
    wire rxd_in = rxd_oe ? rxd_out : peer_rxd;
    int err_total = 0;
    int n_tests = 0;
    logic [9:0] v, g;

    spu_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer1_ovf(timer1_ovf),
        .timer2_ovf(timer2_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
        .txd(txd));
    spu_peer u_peer (.clk(clk), .txd(txd), .rxd(peer_rxd));

    always #2 clk = ~clk;

    // Both timers overflow every second clock while running.
    always @(posedge clk) begin
        timer1_ovf <= t_run & ~timer1_ovf;
        timer2_ovf <= t_run & ~timer2_ovf;
    end

    task automatic wrap_up();
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [9:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = {2'b00, reg_rdata};
        @(posedge clk);
    endtask : rd

    task automatic t_reg();
        rd(8'h98, v);
        check(v, 10'h000);
        wr(8'h55, 8'hff);
        rd(8'h55, v);
        check(v, 10'h000);
    endtask : t_reg

    task automatic t_tx9();
        logic [7:0] pw [2] = '{8'h80, 8'h00};
        logic [7:0] dt [2] = '{8'ha5, 8'h3c};
        for (int i = 0; i < 2; i++) begin
            wr(8'h87, pw[i]);
            wr(8'h98, {4'h8, i[0] ? 4'h0 : 4'h8});
            wr(8'h99, dt[i]);
            u_peer.grab(g, 10, i[0] ? 64 : 32);
            check(g, {1'b1, ~i[0], dt[i]});
            repeat (64) @(posedge clk);
            rd(8'h98, v);
            check(v, {2'b00, 4'h8, i[0] ? 4'h2 : 4'ha});
        end
    endtask : t_tx9

    task automatic t_rx9();
        logic [7:0] c [4] = '{8'hb0, 8'hb0, 8'ha0, 8'h90};
        logic [7:0] e [4] = '{8'hb0, 8'hb5, 8'ha0, 8'h91};
        wr(8'h87, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wr(8'h98, c[i]);
            u_peer.send({1'b1, i == 1 || i == 2, 8'h61 + 8'(i)}, 10, 32);
            repeat (8) @(posedge clk);
            rd(8'h98, v);
            check(v & 10'h001, {9'h0, e[i][0]});
            if (e[i][0]) begin
                check(v, {2'b00, e[i]});
                rd(8'h99, v);
                check(v, {2'b00, 8'h61 + 8'(i)});
            end
        end
    endtask : t_rx9

    task automatic t_uart1();
        t_run <= 1'b1;
        wr(8'hc8, 8'h30);
        wr(8'h98, 8'h50);
        wr(8'h99, 8'h5a);
        u_peer.grab(g, 9, 32);
        check(g, 10'h15a);
        repeat (40) @(posedge clk);
        wr(8'h98, 8'h50);
        u_peer.send(10'h1c3, 9, 32);
        repeat (8) @(posedge clk);
        rd(8'h98, v);
        check(v, 10'h055);
        wr(8'h98, 8'h70);
        u_peer.send(10'h0c3, 9, 32);
        repeat (8) @(posedge clk);
        rd(8'h98, v);
        check(v & 10'h001, 10'h000);
        wr(8'hc8, 8'h00);
        wr(8'h98, 8'hc8);
        wr(8'h99, 8'he7);
        u_peer.grab(g, 10, 32);
        check(g, 10'h3e7);
        repeat (40) @(posedge clk);
        t_run <= 1'b0;
    endtask : t_uart1

    task automatic t_shift();
        int k;
        k = 0;
        wr(8'h98, 8'h00);
        wr(8'h99, 8'h96);
        while (rxd_oe !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        check({9'h0, rxd_oe}, 10'h001);
        repeat (6) @(posedge clk);
        g = '0;
        for (int i = 0; i < 8; i++) begin
            g[i] = rxd_out;
            repeat (12) @(posedge clk);
        end
        check(g, 10'h096);
        rd(8'h98, v);
        check(v, 10'h002);
    endtask : t_shift

    task automatic t_shift_rx();
        wr(8'h98, 8'h10);
        u_peer.shift_in(8'h4b);
        check({9'h0, rxd_oe}, 10'h000);
        repeat (16) @(posedge clk);
        rd(8'h98, v);
        check(v, 10'h011);
        rd(8'h99, v);
        check(v, 10'h04b);
    endtask : t_shift_rx

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reg();
        t_tx9();
        t_rx9();
        t_uart1();
        t_shift();
        t_shift_rx();
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule : serial_port_uart_tb_top

`default_nettype wire

// [spu_baud_gen.sv]
`timescale 1ns/10ps
`default_nettype none
`include "spu_params.svh"

module spu_baud_gen #(
    parameter int FAST_DIV = `SPU_M2_DIV_FAST,
    parameter int SLOW_DIV = `SPU_M2_DIV_SLOW
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] mode,
    input wire logic doubler,
    input wire logic tx_t2,
    input wire logic rx_t2,
    input wire logic t1_ovf,
    input wire logic t2_ovf,
    spu_tick_if.gen tick
);
    logic t1_half_q;
    logic [2:0] m2_cnt_q;
    logic [2:0] m2_last;
    logic t1_tick;
    logic m2_tick;

    if (FAST_DIV < 1 || SLOW_DIV > 8 || FAST_DIV > SLOW_DIV) begin : g_chk
        $error("spu_baud_gen: unsupported divider");
    end

    // Timer 1 overflows are halved unless the doubler is set.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            t1_half_q <= 1'b0;
        end else if (t1_ovf) begin
            t1_half_q <= ~t1_half_q;
        end
    end
    assign t1_tick = t1_ovf & (doubler | t1_half_q);

    // Fixed oversampling tick of the fixed-rate nine-bit mode.
    assign m2_last = doubler ? 3'(FAST_DIV - 1) : 3'(SLOW_DIV - 1);
    assign m2_tick = (m2_cnt_q == m2_last);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m2_cnt_q <= 3'h0;
        end else if (m2_cnt_q >= m2_last) begin
            m2_cnt_q <= 3'h0;
        end else begin
            m2_cnt_q <= m2_cnt_q + 3'h1;
        end
    end

    // Variable modes take Timer 2 directly or Timer 1 scaled by the doubler.
    assign tick.tx_tick = (mode == 2'b10) ? m2_tick : (tx_t2 ? t2_ovf : t1_tick);
    assign tick.rx_tick = (mode == 2'b10) ? m2_tick : (rx_t2 ? t2_ovf : t1_tick);

    rx_timer2_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode[0] && rx_t2) |-> (tick.rx_tick == t2_ovf))
        else $error("receive tick does not follow Timer 2");

    fixed_rate_slow_a: assert property (@(posedge clk) disable iff (!resetn)
        (m2_tick && !doubler ##1 !doubler [*3]) |=> m2_tick)
        else $error("slow fixed rate tick spacing wrong");

endmodule : spu_baud_gen

`default_nettype wire

// [spu_params.svh]
`ifndef SPU_PARAMS_SVH
`define SPU_PARAMS_SVH

// Register addresses on the plain register port.
`define SPU_ADDR_CTRL 8'h98
`define SPU_ADDR_DATA 8'h99
`define SPU_ADDR_PWR 8'h87
`define SPU_ADDR_CLKSEL 8'hc8
`define SPU_CTRL_RESET 8'h00

// Field positions in the serial control register.
`define SPU_B_MODE_HI 7
`define SPU_B_MODE_LO 6
`define SPU_B_FILTER 5
`define SPU_B_RXEN 4
`define SPU_B_TX9 3
`define SPU_B_RX9 2
`define SPU_B_TXDONE 1
`define SPU_B_RXDONE 0

// Field positions in the power and clock select registers.
`define SPU_B_DOUBLER 7
`define SPU_B_RXT2 5
`define SPU_B_TXT2 4

// Divider counts in clk cycles, oversampling counts in baud ticks; clk stands for twice the CPU clock.
`define SPU_M0_DIV 12
`define SPU_M2_DIV_FAST 2
`define SPU_M2_DIV_SLOW 4
`define SPU_OVS_LAST 4'hf
`define SPU_OVS_MID 4'h7

`endif

// [spu_peer.sv]
`timescale 1ns/10ps
`default_nettype none

module spu_peer (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;

    // Sends a low start bit, then n bits LSB first with the stop bit last.
    task automatic send(input logic [9:0] bits, input int n, input int per);
        rxd <= 1'b0;
        repeat (per) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (per) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (per) @(posedge clk);
    endtask : send

    // Waits for a start bit and samples n bits at their middles.
    task automatic grab(output logic [9:0] got, input int n, input int per);
        int k;
        got = '0;
        k = 0;
        while (txd !== 1'b0 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (per) @(posedge clk);
            got[i] = txd;
        end
    endtask : grab

    // Puts the next bit on the data pin after each falling shift clock, LSB first.
    task automatic shift_in(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            rxd <= b[i];
        end
    endtask : shift_in
endmodule : spu_peer

`default_nettype wire

// [spu_pkg.sv]
`default_nettype none

package spu_pkg;

    typedef enum logic [1:0] {
        SPU_SHIFT = 2'b00,
        SPU_UART8 = 2'b01,
        SPU_UART9_FIXED = 2'b10,
        SPU_UART9_VAR = 2'b11
    } spu_mode_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_NINTH = 3'b011,
        TX_STOP = 3'b100,
        TX_SHIFT0 = 3'b101
    } spu_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } spu_rx_e;

endpackage : spu_pkg

`default_nettype wire

// [spu_tick_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface spu_tick_if;
    logic tx_tick;
    logic rx_tick;
    modport gen (output tx_tick, output rx_tick);
    modport sink (input tx_tick, input rx_tick);
endinterface : spu_tick_if

`default_nettype wire

// [spu_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "spu_params.svh"


module spu_top #(
    parameter int M0_DIV = `SPU_M0_DIV
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer1_ovf,
    input wire logic timer2_ovf,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd
);
    logic [7:0] ctrl_q;
    logic [7:0] rx_buf_q;
    logic [7:0] rdata_q;
    logic doubler_q;
    logic rx_t2_q;
    logic tx_t2_q;
    logic rxd_m_q;
    logic rxd_s_q;
    spu_pkg::spu_tx_e tx_st_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic [3:0] tcnt_q;
    logic [3:0] div_q;
    logic m0_rx_q;
    logic txd_q;
    logic rxd_out_q;
    logic rxd_oe_q;
    logic [1:0] mode;
    logic mode0;
    logic nine;
    logic filter;
    logic ren;
    logic data_wr;
    logic ctrl_wr;
    logic tx_bit_end;
    logic m0_end;
    logic m0_done;
    logic ti_set;
    logic ri_set;
    logic rx_accept;
    logic rb8_load;
    logic rb8_val;
    logic u_done;
    logic [7:0] u_data;
    logic u_ninth;
    logic u_stop;

    spu_tick_if tick_if ();

    if (M0_DIV < 2 || M0_DIV > 16) begin : g_chk
        $error("spu_top: shift divider out of range");
    end

    assign mode = ctrl_q[`SPU_B_MODE_HI:`SPU_B_MODE_LO];
    assign mode0 = (mode == spu_pkg::SPU_SHIFT);
    assign nine = mode[1];
    assign filter = ctrl_q[`SPU_B_FILTER];
    assign ren = ctrl_q[`SPU_B_RXEN];
    assign data_wr = reg_wr && (reg_addr == `SPU_ADDR_DATA);
    assign ctrl_wr = reg_wr && (reg_addr == `SPU_ADDR_CTRL);

    // Two-stage synchroniser on the serial input pin.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxd_m_q <= 1'b1;
            rxd_s_q <= 1'b1;
        end else begin
            rxd_m_q <= rxd_in;
            rxd_s_q <= rxd_m_q;
        end
    end

    spu_baud_gen u_baud (
        .clk (clk),
        .resetn (resetn),
        .mode (mode),
        .doubler (doubler_q),
        .tx_t2 (tx_t2_q),
        .rx_t2 (rx_t2_q),
        .t1_ovf (timer1_ovf),
        .t2_ovf (timer2_ovf),
        .tick (tick_if.gen)
    );

    spu_uart_rx u_rx (
        .clk (clk),
        .resetn (resetn),
        .tick (tick_if.rx_tick),
        .rxd (rxd_s_q),
        .enable (ren && !mode0),
        .nine (nine),
        .done_q (u_done),
        .data_q (u_data),
        .ninth_q (u_ninth),
        .stop_q (u_stop)
    );

    assign tx_bit_end = tick_if.tx_tick && (tcnt_q == `SPU_OVS_LAST);
    assign m0_end = (div_q == 4'(M0_DIV - 1));
    assign m0_done = (tx_st_q == spu_pkg::TX_SHIFT0) && m0_end && (bit_q == 4'h7);

    // Transmit engine; shift register mode also uses it for reception.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_st_q <= spu_pkg::TX_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            tcnt_q <= 4'h0;
            div_q <= 4'h0;
            m0_rx_q <= 1'b0;
        end else begin
            case (tx_st_q)
                spu_pkg::TX_IDLE: begin
                    tcnt_q <= 4'h0;
                    bit_q <= 4'h0;
                    div_q <= 4'h0;
                    if (data_wr) begin
                        sh_q <= reg_wdata;
                        m0_rx_q <= 1'b0;
                        tx_st_q <= mode0 ? spu_pkg::TX_SHIFT0 : spu_pkg::TX_START;
                    end else if (mode0 && ren && !ctrl_q[`SPU_B_RXDONE]) begin
                        m0_rx_q <= 1'b1;
                        tx_st_q <= spu_pkg::TX_SHIFT0;
                    end
                end
                spu_pkg::TX_SHIFT0: begin
                    div_q <= m0_end ? 4'h0 : div_q + 4'h1;
                    if (m0_end) begin
                        sh_q <= {m0_rx_q ? rxd_s_q : 1'b0, sh_q[7:1]};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7) begin
                            tx_st_q <= spu_pkg::TX_IDLE;
                        end
                    end
                end
                default: begin
                    if (tick_if.tx_tick) begin
                        tcnt_q <= tcnt_q + 4'h1;
                    end
                    if (tx_bit_end) begin
                        case (tx_st_q)
                            spu_pkg::TX_START: tx_st_q <= spu_pkg::TX_DATA;
                            spu_pkg::TX_DATA: begin
                                sh_q <= {1'b0, sh_q[7:1]};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h7) begin
                                    tx_st_q <= nine ? spu_pkg::TX_NINTH : spu_pkg::TX_STOP;
                                end
                            end
                            spu_pkg::TX_NINTH: tx_st_q <= spu_pkg::TX_STOP;
                            default: tx_st_q <= spu_pkg::TX_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // Line drivers; in shift mode the transmit pin carries the shift clock.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txd_q <= 1'b1;
            rxd_out_q <= 1'b1;
            rxd_oe_q <= 1'b0;
        end else begin
            case (tx_st_q)
                spu_pkg::TX_START: txd_q <= 1'b0;
                spu_pkg::TX_DATA: txd_q <= sh_q[0];
                spu_pkg::TX_NINTH: txd_q <= ctrl_q[`SPU_B_TX9];
                spu_pkg::TX_SHIFT0: txd_q <= (div_q >= 4'(M0_DIV / 2));
                default: txd_q <= 1'b1;
            endcase
            rxd_out_q <= sh_q[0];
            rxd_oe_q <= (tx_st_q == spu_pkg::TX_SHIFT0) && !m0_rx_q;
        end
    end
    assign txd = txd_q;
    assign rxd_out = rxd_out_q;
    assign rxd_oe = rxd_oe_q;

    // Flag events and the multiprocessor filter.
    assign ti_set = (m0_done && !m0_rx_q) || (tx_bit_end && (tx_st_q == spu_pkg::TX_NINTH
        || (tx_st_q == spu_pkg::TX_DATA && bit_q == 4'h7 && !nine)));
    always_comb begin
        case (mode)
            spu_pkg::SPU_UART8: rx_accept = !filter || u_stop;
            spu_pkg::SPU_UART9_FIXED, spu_pkg::SPU_UART9_VAR: begin
                rx_accept = !filter || u_ninth;
            end
            default: rx_accept = 1'b0;
        endcase
    end
    assign ri_set = (m0_done && m0_rx_q) || (u_done && rx_accept);
    assign rb8_load = u_done && rx_accept && (nine || !filter);
    assign rb8_val = nine ? u_ninth : u_stop;

    // Control register; a hardware set beats a software clear in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SPU_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= reg_wdata;
            end
            if (ti_set) begin
                ctrl_q[`SPU_B_TXDONE] <= 1'b1;
            end
            if (ri_set) begin
                ctrl_q[`SPU_B_RXDONE] <= 1'b1;
            end
            if (rb8_load) begin
                ctrl_q[`SPU_B_RX9] <= rb8_val;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_buf_q <= 8'h00;
        end else if (m0_done && m0_rx_q) begin
            rx_buf_q <= {rxd_s_q, sh_q[7:1]};
        end else if (u_done && rx_accept) begin
            rx_buf_q <= u_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doubler_q <= 1'b0;
            rx_t2_q <= 1'b0;
            tx_t2_q <= 1'b0;
        end else if (reg_wr && reg_addr == `SPU_ADDR_PWR) begin
            doubler_q <= reg_wdata[`SPU_B_DOUBLER];
        end else if (reg_wr && reg_addr == `SPU_ADDR_CLKSEL) begin
            rx_t2_q <= reg_wdata[`SPU_B_RXT2];
            tx_t2_q <= reg_wdata[`SPU_B_TXT2];
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (!reg_rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (reg_addr)
                `SPU_ADDR_CTRL: rdata_q <= ctrl_q;
                `SPU_ADDR_DATA: rdata_q <= rx_buf_q;
                `SPU_ADDR_PWR: rdata_q <= {doubler_q, 7'h00};
                `SPU_ADDR_CLKSEL: rdata_q <= {2'h0, rx_t2_q, tx_t2_q, 4'h0};
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = rdata_q;

    filter_ninth_a: assert property (@(posedge clk) disable iff (!resetn)
        (u_done && nine && filter && !u_ninth && !ctrl_wr)
        |=> ctrl_q[`SPU_B_RXDONE] == $past(ctrl_q[`SPU_B_RXDONE]))
        else $error("receive flag raised for ninth bit zero");

    filter_stop_a: assert property (@(posedge clk) disable iff (!resetn)
        (u_done && mode == 2'b01 && filter && !u_stop && !ctrl_wr && !m0_done)
        |=> ctrl_q[`SPU_B_RXDONE] == $past(ctrl_q[`SPU_B_RXDONE]))
        else $error("receive flag raised for bad stop bit");

    ninth_sent_a: assert property (@(posedge clk) disable iff (!resetn)
        (tx_st_q == spu_pkg::TX_NINTH) |=> txd_q == $past(ctrl_q[`SPU_B_TX9]))
        else $error("ninth transmit bit wrong on the line");

    ninth_recv_a: assert property (@(posedge clk) disable iff (!resetn)
        (u_done && rx_accept && nine) |=> ctrl_q[`SPU_B_RX9] == $past(u_ninth))
        else $error("received ninth bit not stored");

    tx_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        (tx_bit_end && tx_st_q == spu_pkg::TX_NINTH)
        |=> ctrl_q[`SPU_B_TXDONE] && tx_st_q == spu_pkg::TX_STOP)
        else $error("transmit flag not set at stop start");

    shift_rx_flag_a: assert property (@(posedge clk) disable iff (!resetn)
        (m0_done && m0_rx_q) |=> ctrl_q[`SPU_B_RXDONE] && tx_st_q == spu_pkg::TX_IDLE)
        else $error("receive flag not set after eighth shift bit");

    shift_time_a: assert property (@(posedge clk) disable iff (!resetn)
        (tx_st_q == spu_pkg::TX_SHIFT0 && div_q == 4'h0 && bit_q == 4'h0)
        |-> ##95 (tx_st_q == spu_pkg::TX_SHIFT0) ##1 (tx_st_q == spu_pkg::TX_IDLE))
        else $error("shift mode byte not 96 clocks long");

endmodule : spu_top

`default_nettype wire

// [spu_uart_rx.sv]
`timescale 1ns/10ps
`default_nettype none
`include "spu_params.svh"

module spu_uart_rx (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic rxd,
    input wire logic enable,
    input wire logic nine,
    output logic done_q,
    output logic [7:0] data_q,
    output logic ninth_q,
    output logic stop_q
);
    spu_pkg::spu_rx_e st_q;
    logic [3:0] cnt_q;
    logic [3:0] bit_q;
    logic prev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= rxd;
        end
    end

    // Each bit is sixteen ticks long and sampled at its middle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= spu_pkg::RX_IDLE;
            cnt_q <= 4'h0;
            bit_q <= 4'h0;
            done_q <= 1'b0;
            data_q <= 8'h00;
            ninth_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (!enable) begin
                st_q <= spu_pkg::RX_IDLE;
            end else begin
                case (st_q)
                    spu_pkg::RX_IDLE: begin
                        cnt_q <= 4'h0;
                        bit_q <= 4'h0;
                        if (prev_q && !rxd) begin
                            st_q <= spu_pkg::RX_START;
                        end
                    end
                    spu_pkg::RX_START: begin
                        if (tick) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == `SPU_OVS_MID && rxd) begin
                                st_q <= spu_pkg::RX_IDLE;
                            end else if (cnt_q == `SPU_OVS_LAST) begin
                                st_q <= spu_pkg::RX_DATA;
                            end
                        end
                    end
                    spu_pkg::RX_DATA: begin
                        if (tick) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == `SPU_OVS_MID) begin
                                if (bit_q[3]) begin
                                    ninth_q <= rxd;
                                end else begin
                                    data_q[bit_q[2:0]] <= rxd;
                                end
                            end
                            if (cnt_q == `SPU_OVS_LAST) begin
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == (nine ? 4'h8 : 4'h7)) begin
                                    st_q <= spu_pkg::RX_STOP;
                                end
                            end
                        end
                    end
                    spu_pkg::RX_STOP: begin
                        if (tick) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == `SPU_OVS_MID) begin
                                stop_q <= rxd;
                                done_q <= 1'b1;
                                st_q <= spu_pkg::RX_IDLE;
                            end
                        end
                    end
                    default: st_q <= spu_pkg::RX_IDLE;
                endcase
            end
        end
    end

    rx_disable_a: assert property (@(posedge clk) disable iff (!resetn)
        !enable |=> (st_q == spu_pkg::RX_IDLE) && !done_q)
        else $error("receiver active while disabled");

endmodule : spu_uart_rx

`default_nettype wire
